// file: verilog/tiu_top.v
// Two 16-bit timers with capture, compare, buffered compare and PWM.
`timescale 1ns/100ps
`include "tiu_map.vh"

// Functional notes
// RL1: 16-bit counter, free-running or modulo up-count.
// RL2: Modulo high and low bytes set wrap value.
// RL3: Counter readable anytime without disturbing it.
// RL4: Two channels each capture or compare.
// RL5: Two identical timers with own registers.
// RL6: Unbuffered compare uses current channel value.
// RL7: Unsynchronised rewrite may upset two periods.
// RL8: Compare flag raised on counter match.
// RL9: Overflow flag raised at each wrap.
// RL10: Software lowers value inside compare interrupt.
// RL11: Software raises value inside overflow interrupt.
// RL12: Larger value at compare may match twice.
// RL13: Link bit joins channels onto channel zero pin.
// RL14: After linking channel zero value controls first.
// RL15: Channel one write takes over at overflow.
// RL16: Each overflow selects last written channel.
// RL17: Linked channel one control unused, pin released.
// RL18: Software writes only the inactive linked channel.
// RL19: Toggle-on-overflow toggles pin at wrap.
// RL20: Pulse width is overflow to compare time.
// RL21: Modulo wrap to zero after match is overflow.
// RL22: Enables for toggle, compare and overflow interrupts.
module tiu_top (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [6:2] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [3:0] ch_pin_i,
    output wire [3:0] ch_pin_o,
    output reg [3:0] ch_oe_o,
    output reg [1:0] ovf_irq_o,
    output reg [3:0] cmp_irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Per-timer state, index is the timer number minus one.
    reg [15:0] cnt [0:1];
    reg [15:0] modulo [0:1];
    reg [1:0] tmod_en;
    reg [1:0] tovf_ie;
    reg [1:0] tovf_flag;
    reg [1:0] act_sel;
    reg [1:0] last_wr;

    // Per-channel state, index is timer times two plus channel.
    reg [15:0] ch_val [0:3];
    reg [3:0] ch_oc_en;
    reg [3:0] ch_tov;
    reg [3:0] ch_ie;
    reg [3:0] ch_link;

    wire [3:0] ch_flag;
    wire [3:0] ch_cap;
    reg [3:0] ch_match;
    reg [3:0] ch_oc_eff;
    reg [3:0] ch_tov_eff;
    reg [3:0] ch_fclr;
    reg [1:0] ovf;
    reg [15:0] cmp_val;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode.
    wire wb_req;
    wire wb_wr;
    wire tsel;
    wire [2:0] ridx;
    reg [31:0] rdata;

    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr = wb_req & wb_we_i & ~wb_adr_i[`TIU_A_TIMER];
    assign tsel = wb_adr_i[`TIU_A_TIMER + 1]; // RL5
    assign ridx = wb_adr_i[4:2];

    ////////////////////////////////////////////////////////////////////////
    // Overflow and match detection.
    integer i;
    integer k;

    always @* begin
        ovf = 2'b00;
        ch_match = 4'h0;
        ch_oc_eff = 4'h0;
        ch_tov_eff = 4'h0;
        cmp_val = 16'h0000;
        for (i = 0; i < 2; i = i + 1) begin
            if (tmod_en[i]) begin
                ovf[i] = (cnt[i] == modulo[i]); // RL21
            end else begin
                ovf[i] = (cnt[i] == `TIU_CNT_MAX); // RL1
            end
        end
        for (k = 0; k < 4; k = k + 1) begin
            if (k % 2 == 0 && ch_link[k]) begin
                // Linked pair compares the active register set.
                if (act_sel[k / 2]) begin
                    cmp_val = ch_val[k + 1]; // RL16
                end else begin
                    cmp_val = ch_val[k]; // RL14
                end
                ch_oc_eff[k] = 1'b1; // RL13
                ch_tov_eff[k] = ch_tov[k];
            end else if (k % 2 == 1 && ch_link[k - 1]) begin
                cmp_val = ch_val[k];
                ch_oc_eff[k] = 1'b0; // RL17
                ch_tov_eff[k] = 1'b0;
            end else begin
                cmp_val = ch_val[k]; // RL6
                ch_oc_eff[k] = ch_oc_en[k];
                ch_tov_eff[k] = ch_tov[k];
            end
            ch_match[k] = ch_oc_eff[k] & (cnt[k / 2] == cmp_val);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag clears by writing one to the flag bit of a channel control.
    always @* begin
        ch_fclr = 4'h0;
        if (wb_wr && wb_sel_i[0]) begin
            if (ridx == `TIU_R_C0CTL) begin
                ch_fclr[{tsel, 1'b0}] = wb_dat_i[`TIU_B_CF];
            end
            if (ridx == `TIU_R_C1CTL) begin
                ch_fclr[{tsel, 1'b1}] = wb_dat_i[`TIU_B_CF];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels.
    wire [3:0] cap_pin;

    // A linked channel one leaves its pin to general use.
    assign cap_pin = ch_pin_i & ~{ch_link[2], 1'b0, ch_link[0], 1'b0}; // RL17

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gch
            tiu_chan u_chan (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .oc_en_i(ch_oc_eff[g]),
                .tov_i(ch_tov_eff[g]),
                .ovf_i(ovf[g / 2]),
                .match_i(ch_match[g]),
                .flag_clr_i(ch_fclr[g]),
                .pin_i(cap_pin[g]),
                .cap_o(ch_cap[g]),
                .flag_o(ch_flag[g]),
                .pin_o(ch_pin_o[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Counters, timer control and buffered compare selection.
    integer t;

    always @(posedge clk_i) begin
        if (rst_i) begin
            for (t = 0; t < 2; t = t + 1) begin
                cnt[t] <= 16'h0000;
                modulo[t] <= `TIU_MOD_RST;
            end
            tmod_en <= 2'b00;
            tovf_ie <= 2'b00;
            tovf_flag <= 2'b00;
            act_sel <= 2'b00;
            last_wr <= 2'b00;
        end else begin
            for (t = 0; t < 2; t = t + 1) begin
                // Reads never touch the counter.
                if (ovf[t]) begin
                    cnt[t] <= 16'h0000; // RL21
                end else begin
                    cnt[t] <= cnt[t] + 16'h0001; // RL1 RL3
                end
                if (ovf[t]) begin
                    tovf_flag[t] <= 1'b1; // RL9
                    act_sel[t] <= last_wr[t]; // RL15 RL16
                end
                if (wb_wr && tsel == t[0]) begin
                    if (ridx == `TIU_R_CTRL && wb_sel_i[0]) begin
                        tmod_en[t] <= wb_dat_i[`TIU_B_MODEN]; // RL1
                        tovf_ie[t] <= wb_dat_i[`TIU_B_OVFIE]; // RL22
                        if (wb_dat_i[`TIU_B_OVFF] && !ovf[t]) begin
                            tovf_flag[t] <= 1'b0;
                        end
                        if (wb_dat_i[`TIU_B_CRST]) begin
                            cnt[t] <= 16'h0000;
                        end
                    end
                    if (ridx == `TIU_R_MOD) begin
                        if (wb_sel_i[1]) begin
                            modulo[t][15:8] <= wb_dat_i[15:8]; // RL2
                        end
                        if (wb_sel_i[0]) begin
                            modulo[t][7:0] <= wb_dat_i[7:0]; // RL2
                        end
                    end
                    if (ridx == `TIU_R_C0CTL && wb_sel_i[0]) begin
                        if (wb_dat_i[`TIU_B_LINK] && !ch_link[2 * t]) begin
                            act_sel[t] <= 1'b0; // RL14
                            last_wr[t] <= 1'b0;
                        end
                    end
                    if (ch_link[2 * t] && |wb_sel_i[1:0]) begin
                        if (ridx == `TIU_R_C0VAL) begin
                            last_wr[t] <= 1'b0; // RL16
                        end
                        if (ridx == `TIU_R_C1VAL) begin
                            last_wr[t] <= 1'b1; // RL15
                        end
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel control and value registers.
    integer j;

    always @(posedge clk_i) begin
        if (rst_i) begin
            for (j = 0; j < 4; j = j + 1) begin
                ch_val[j] <= `TIU_VAL_RST;
            end
            ch_oc_en <= 4'h0;
            ch_tov <= 4'h0;
            ch_ie <= 4'h0;
            ch_link <= 4'h0;
        end else begin
            for (j = 0; j < 4; j = j + 1) begin
                if (wb_wr && tsel == j[1] && wb_sel_i[0]) begin
                    if ((j % 2 == 0 && ridx == `TIU_R_C0CTL) ||
                        (j % 2 == 1 && ridx == `TIU_R_C1CTL)) begin
                        ch_oc_en[j] <= wb_dat_i[`TIU_B_OCEN]; // RL4
                        ch_tov[j] <= wb_dat_i[`TIU_B_TOV]; // RL22
                        ch_ie[j] <= wb_dat_i[`TIU_B_CIE]; // RL22
                        if (j % 2 == 0) begin
                            ch_link[j] <= wb_dat_i[`TIU_B_LINK]; // RL13
                        end
                    end
                end
                if (wb_wr && tsel == j[1]) begin
                    if ((j % 2 == 0 && ridx == `TIU_R_C0VAL) ||
                        (j % 2 == 1 && ridx == `TIU_R_C1VAL)) begin
                        if (wb_sel_i[1]) begin
                            ch_val[j][15:8] <= wb_dat_i[15:8]; // RL6 RL7
                        end
                        if (wb_sel_i[0]) begin
                            ch_val[j][7:0] <= wb_dat_i[7:0]; // RL6 RL7
                        end
                    end
                end
                // A capture wins over a software write.
                if (ch_cap[j]) begin
                    ch_val[j] <= cnt[j / 2];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin enables and interrupt requests.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ch_oe_o <= 4'h0;
            ovf_irq_o <= 2'b00;
            cmp_irq_o <= 4'h0;
        end else begin
            ch_oe_o <= ch_oc_eff; // RL17
            ovf_irq_o <= tovf_flag & tovf_ie; // RL9
            cmp_irq_o <= ch_flag & ch_ie; // RL8
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer.
    always @* begin
        rdata = 32'h00000000;
        case (ridx)
            `TIU_R_CTRL: begin
                rdata[`TIU_B_MODEN] = tmod_en[tsel];
                rdata[`TIU_B_OVFIE] = tovf_ie[tsel];
                rdata[`TIU_B_OVFF] = tovf_flag[tsel];
            end
            `TIU_R_COUNT: begin
                rdata[15:0] = cnt[tsel]; // RL3
            end
            `TIU_R_MOD: begin
                rdata[15:0] = modulo[tsel];
            end
            `TIU_R_C0CTL: begin
                rdata[`TIU_B_OCEN] = ch_oc_en[{tsel, 1'b0}];
                rdata[`TIU_B_TOV] = ch_tov[{tsel, 1'b0}];
                rdata[`TIU_B_CIE] = ch_ie[{tsel, 1'b0}];
                rdata[`TIU_B_CF] = ch_flag[{tsel, 1'b0}];
                rdata[`TIU_B_LINK] = ch_link[{tsel, 1'b0}];
            end
            `TIU_R_C0VAL: begin
                rdata[15:0] = ch_val[{tsel, 1'b0}];
            end
            `TIU_R_C1CTL: begin
                rdata[`TIU_B_OCEN] = ch_oc_en[{tsel, 1'b1}];
                rdata[`TIU_B_TOV] = ch_tov[{tsel, 1'b1}];
                rdata[`TIU_B_CIE] = ch_ie[{tsel, 1'b1}];
                rdata[`TIU_B_CF] = ch_flag[{tsel, 1'b1}];
            end
            `TIU_R_C1VAL: begin
                rdata[15:0] = ch_val[{tsel, 1'b1}];
            end
            default: begin
                rdata = 32'h00000000;
            end
        endcase
        if (wb_adr_i[`TIU_A_TIMER]) begin
            rdata = 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, ack for one cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rdata;
            end
        end
    end

endmodule

// file: verilog/tiu_map.vh
// Register offsets, field positions and reset values of the timer block.
`ifndef TIU_MAP_VH
`define TIU_MAP_VH

////////////////////////////////////////////////////////////////////////////
// Word index of each register inside one timer window.
`define TIU_R_CTRL 3'h0
`define TIU_R_COUNT 3'h1
`define TIU_R_MOD 3'h2
`define TIU_R_C0CTL 3'h3
`define TIU_R_C0VAL 3'h4
`define TIU_R_C1CTL 3'h5
`define TIU_R_C1VAL 3'h6

// Address bit that must be zero for a mapped register; the bit above it selects timer 1 or timer 2.
`define TIU_A_TIMER 5

////////////////////////////////////////////////////////////////////////////
// Timer control register fields.
`define TIU_B_MODEN 0
`define TIU_B_OVFIE 1
`define TIU_B_OVFF 2
`define TIU_B_CRST 3

// Channel control register fields.
`define TIU_B_OCEN 0
`define TIU_B_TOV 1
`define TIU_B_CIE 2
`define TIU_B_CF 3
`define TIU_B_LINK 4

////////////////////////////////////////////////////////////////////////////
// Reset values and the free-running wrap value.
`define TIU_MOD_RST 16'hFFFF
`define TIU_CNT_MAX 16'hFFFF
`define TIU_VAL_RST 16'h0000

`endif

// file: verilog/tiu_chan.v
// One capture or compare channel with its pin logic and event flag.
`timescale 1ns/100ps

module tiu_chan (
    input wire clk_i,
    input wire rst_i,
    input wire oc_en_i,
    input wire tov_i,
    input wire ovf_i,
    input wire match_i,
    input wire flag_clr_i,
    input wire pin_i,
    output wire cap_o,
    output reg flag_o,
    output reg pin_o
);

    reg pin_prev;
    wire evt;
    wire tgl;

    ////////////////////////////////////////////////////////////////////////
    // Rising edge on the pin captures while the channel is in capture mode.
    assign cap_o = ~oc_en_i & pin_i & ~pin_prev; // RL4
    assign evt = oc_en_i ? match_i : cap_o;
    // Compare toggles the pin, as does the overflow when enabled; a match and an enabled overflow in the same cycle cancel.
    assign tgl = match_i ^ (tov_i & ovf_i); // RL19 RL20

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_prev <= 1'b0;
            flag_o <= 1'b0;
            pin_o <= 1'b0;
        end else begin
            pin_prev <= pin_i;
            // A new event wins over a clear in the same cycle.
            flag_o <= evt | (flag_o & ~flag_clr_i); // RL8
            if (!oc_en_i) begin
                pin_o <= 1'b0;
            end else if (tgl) begin
                pin_o <= ~pin_o; // RL6 RL12
            end
        end
    end

endmodule

// file: testbench/tiu_monitor.sv
// Checker of bus and pin behaviour at the timer block ports.
`timescale 1ns/100ps
module tiu_monitor (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [6:2] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [3:0] ch_oe_o,
    input wire [1:0] ovf_irq_o,
    input wire [3:0] cmp_irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire ctl_wr = wr & (wb_adr_i == 5'h00);
    wire cc_wr = wr & (wb_adr_i == 5'h03);
    wire bad = wb_adr_i[5] | (wb_adr_i[4:2] == 3'h7);

    a_ack_next: assert property (req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_idle: assert property (!(wb_cyc_i & wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data changed without ack");
    a_unmapped_zero: assert property (req & !wb_we_i & bad
        |=> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    a_ovf_clear: assert property ($fell(ovf_irq_o[0]) |->
        $past(ctl_wr, 1) || $past(ctl_wr, 2) || $past(ctl_wr, 3))
        else $error("overflow request dropped without write");
    a_cmp_clear: assert property ($fell(cmp_irq_o[0]) |->
        $past(cc_wr, 1) || $past(cc_wr, 2) || $past(cc_wr, 3))
        else $error("compare request dropped without write");
    a_oe_by_write: assert property ($changed(ch_oe_o) |->
        $past(wr, 1) || $past(wr, 2) || $past(wr, 3))
        else $error("pin enable changed without write");

    c_ovf: cover property ($rose(ovf_irq_o[0]));
    c_cap: cover property ($rose(cmp_irq_o[2]));
    c_release: cover property ($fell(ch_oe_o[1]));
endmodule

bind tiu_top tiu_monitor mon (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ch_oe_o(ch_oe_o), .ovf_irq_o(ovf_irq_o), .cmp_irq_o(cmp_irq_o));

// file: testbench/tiu_pins.sv
// Far side of the channel pins: wire levels, and toggle spacing of the first pin.
`timescale 1ns/100ps
module tiu_pins (
    input wire clk_i,
    input wire [3:0] pin_i,
    input wire [3:0] oe_i,
    input wire [3:0] drv_i,
    output wire [3:0] lvl_o,
    output reg [15:0] d_prev_o = 16'h0000,
    output reg [15:0] d_last_o = 16'h0000
);
    reg [15:0] now = 16'h0000;
    reg [15:0] stamp = 16'h0000;
    reg last = 1'b0;
    // A released pin shows what the far side drives.
    assign lvl_o = (oe_i & pin_i) | (~oe_i & drv_i);
    always @(posedge clk_i) begin
        now <= now + 16'h0001;
        last <= lvl_o[0];
        if (lvl_o[0] != last) begin
            d_prev_o <= d_last_o;
            d_last_o <= now - stamp;
            stamp <= now;
        end
    end
endmodule

// file: testbench/tiu_top_tb.sv
// Register-level tests of the timer block.
`timescale 1ns/100ps
`include "tiu_map.vh"
module tiu_top_tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [6:2] wb_adr_i = 5'h00;
    reg [3:0] wb_sel_i = 4'h0;
    reg [31:0] wb_dat_i = 32'h00000000;
    reg [3:0] drv = 4'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [3:0] lvl, pin_o, oe, cmp;
    wire [1:0] ovf;
    wire [15:0] dp, dl;
    integer failures = 0;
    integer samples_checked = 0;
    integer i;
    reg [31:0] q;
    reg [15:0] c1;

    tiu_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ch_pin_i(lvl), .ch_pin_o(pin_o),
        .ch_oe_o(oe), .ovf_irq_o(ovf), .cmp_irq_o(cmp));
    tiu_pins far (.clk_i(clk_i), .pin_i(pin_o), .oe_i(oe), .drv_i(drv),
        .lvl_o(lvl), .d_prev_o(dp), .d_last_o(dl));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////
    function [6:2] ra(input t, input [2:0] idx);
        ra = {t, 1'b0, idx};
    endfunction

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // One classic cycle; q takes the read data at the ack edge.
    task xfer(input w, input [6:2] a, input [3:0] s, input [15:0] d);
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_sel_i <= s;
            wb_dat_i <= {16'h0000, d};
            do @(posedge clk_i); while (wb_ack_o !== 1'b1);
            q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask

    // Toggle spacing of the first pin against a ten-cycle period.
    task pw(input [15:0] a);
        begin
            repeat (30) @(posedge clk_i);
            chk((dp == a && dl == 16'd10 - a) ||
                (dl == a && dp == 16'd10 - a), 1);
        end
    endtask

    task endt(input [63:0] name);
        $display("test %0s done", name);
    endtask

    task test_done;
        begin
            $display("compares %0d mismatches %0d", samples_checked,
                failures);
            if (failures == 0 && samples_checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    initial begin
        #(5 * 3000);
        failures = failures + 1;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 14; i = i + 1) begin
            xfer(1'b0, ra(i / 7, i % 7), 4'h3, 16'h0000);
            if (i % 7 == 2)
                chk(q[15:0], `TIU_MOD_RST);
            else if (i % 7 != 1)
                chk(q[15:0], 16'h0000);
        end
        xfer(1'b1, 5'h07, 4'h3, 16'hFFFF);
        xfer(1'b0, 5'h07, 4'h3, 16'h0000);
        chk(q, 32'h00000000);
        xfer(1'b1, 5'h08, 4'h3, 16'h0001);
        xfer(1'b0, 5'h08, 4'h3, 16'h0000);
        chk(q, 32'h00000000);
        xfer(1'b0, ra(0, `TIU_R_CTRL), 4'h3, 16'h0000);
        chk(q, 32'h00000000);
        xfer(1'b0, ra(0, `TIU_R_COUNT), 4'h3, 16'h0000);
        c1 = q[15:0];
        xfer(1'b0, ra(0, `TIU_R_COUNT), 4'h3, 16'h0000);
        chk(q[15:0] - c1, 3);
        endt("reset");
        xfer(1'b1, ra(0, `TIU_R_MOD), 4'h1, 16'hAB09);
        xfer(1'b0, ra(0, `TIU_R_MOD), 4'h3, 16'h0000);
        chk(q[15:0], 16'hFF09);
        xfer(1'b1, ra(0, `TIU_R_MOD), 4'h2, 16'h0009);
        xfer(1'b1, ra(0, `TIU_R_CTRL), 4'h3, 16'h000B);
        xfer(1'b0, ra(0, `TIU_R_COUNT), 4'h3, 16'h0000);
        c1 = q[15:0];
        xfer(1'b0, ra(0, `TIU_R_COUNT), 4'h3, 16'h0000);
        chk((q[15:0] + 16'd10 - c1) % 16'd10, 3);
        repeat (12) @(posedge clk_i);
        chk(ovf, 2'b01);
        xfer(1'b1, ra(0, `TIU_R_CTRL), 4'h3, 16'h0005);
        repeat (12) @(posedge clk_i);
        chk(ovf, 2'b00);
        xfer(1'b0, ra(0, `TIU_R_CTRL), 4'h3, 16'h0000);
        chk(q[15:0], 16'h0005);
        endt("modulo");
        xfer(1'b1, ra(0, `TIU_R_C0VAL), 4'h3, 16'h0003);
        xfer(1'b1, ra(0, `TIU_R_C0CTL), 4'h3, 16'h0007);
        pw(16'd4);
        chk(cmp, 4'h1);
        xfer(1'b1, ra(0, `TIU_R_C0CTL), 4'h3, 16'h000F);
        @(posedge clk_i);
        while (cmp[0] !== 1'b1) @(posedge clk_i);
        xfer(1'b1, ra(0, `TIU_R_C0VAL), 4'h3, 16'h0001);
        pw(16'd2);
        xfer(1'b1, ra(0, `TIU_R_CTRL), 4'h3, 16'h0007);
        @(posedge clk_i);
        while (ovf[0] !== 1'b1) @(posedge clk_i);
        xfer(1'b1, ra(0, `TIU_R_C0VAL), 4'h3, 16'h0003);
        pw(16'd4);
        xfer(1'b1, ra(0, `TIU_R_C1CTL), 4'h3, 16'h0001);
        repeat (2) @(posedge clk_i);
        chk(oe, 4'h3);
        xfer(1'b1, ra(0, `TIU_R_C0CTL), 4'h3, 16'h0013);
        repeat (2) @(posedge clk_i);
        chk(oe, 4'h1);
        pw(16'd4);
        xfer(1'b1, ra(0, `TIU_R_C1VAL), 4'h3, 16'h0006);
        pw(16'd7);
        xfer(1'b1, ra(0, `TIU_R_C0VAL), 4'h3, 16'h0001);
        pw(16'd2);
        endt("compare");
        xfer(1'b1, ra(1, `TIU_R_C0CTL), 4'h3, 16'h0004);
        drv <= 4'h4;
        repeat (4) @(posedge clk_i);
        chk(cmp & 4'hC, 4'h4);
        xfer(1'b0, ra(1, `TIU_R_C0VAL), 4'h3, 16'h0000);
        c1 = q[15:0];
        xfer(1'b0, ra(1, `TIU_R_COUNT), 4'h3, 16'h0000);
        chk(q[15:0] - c1 < 16'd20, 1);
        endt("capture");
        test_done;
    end
endmodule
